// [shared/jlit_pkg.sv]
/*
 * Constants and types of the link start-up sequencer of a two-channel serial
 * converter transmitter.
 * Assumes one frame per REF_CLK cycle and a fixed multi-frame length.
 */
package jlit_pkg;

    // ==========================================================
    // Framing
    localparam int unsigned      FRAMES_PER_MF    = 32;
    localparam int unsigned      CYCLES_PER_FRAME = 1;
    localparam logic [4:0]       MF_LAST          = 5'h1F;
    localparam logic [4:0]       MF_FIRST         = 5'h00;
    // First frame of each phase leaves this many frames after the boundary
    localparam int unsigned      LAUNCH_FRAMES    = 6;
    localparam logic [4:0]       LAUNCH_POS       = 5'(LAUNCH_FRAMES * CYCLES_PER_FRAME);
    localparam logic [4:0]       LAUNCH_PRE       = 5'(LAUNCH_FRAMES * CYCLES_PER_FRAME - 1);
    localparam int unsigned      SETUP_FRAMES     = 3;
    localparam int unsigned      ILA_MULTIFRAMES  = 4;
    localparam logic [1:0]       ILA_LAST_MF      = 2'(ILA_MULTIFRAMES - 1);
    localparam int unsigned      RESYNC_FRAMES    = 4;
    localparam logic [2:0]       RESYNC_HOLD      = 3'(RESYNC_FRAMES * CYCLES_PER_FRAME);
    localparam int unsigned      LANE_MBPS_MIN    = 1000;
    localparam int unsigned      LANE_MBPS_MAX    = 7400;

    // ==========================================================
    // Characters and control flags (one flag per octet, high = K)
    localparam logic [7:0]       CHAR_K           = 8'hBC;
    localparam logic [7:0]       CHAR_R           = 8'h1C;
    localparam logic [7:0]       CHAR_A           = 8'h7C;
    localparam logic [1:0]       CTRL_NONE        = 2'h0;
    localparam logic [1:0]       CTRL_LOW         = 2'h1;
    localparam logic [1:0]       CTRL_HIGH        = 2'h2;
    localparam logic [1:0]       CTRL_BOTH        = 2'h3;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LS_WAIT = 2'h0,
        LS_CGS  = 2'h1,
        LS_ILA  = 2'h2,
        LS_DATA = 2'h3
    } jlit_state_t;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
    } jlit_samples_t;

    typedef struct packed {
        logic [1:0]  ctrl;
        logic [15:0] data;
    } jlit_lane_t;

    typedef struct packed {
        jlit_lane_t a;
        jlit_lane_t b;
    } jlit_lanes_t;

endpackage : jlit_pkg

// [hdl/jlit_sync2.sv]
/*
 * Two-stage level synchroniser.
 * Assumes the input may change at any time relative to clk.
 */
`timescale 1ns/1ps
module jlit_sync2 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rst_value,
    input  wire logic d,
    output logic      q
);
    logic stage1;

    // ==========================================================
    // Stages; stage1 feeds nothing but q
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= rst_value;
            q      <= rst_value;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : jlit_sync2

// [hdl/jlit_link_init.sv]
/*
 * Transmit link start-up sequencer: code group sync, lane alignment, data,
 * each launched at a fixed offset from the local multi-frame boundary.
 * Assumes REF_CLK is the frame clock and samples arrive on that clock.
 */
// Operation
// R1: First K28.5 frame leaves six frames after the multi-frame boundary.
// R2: First alignment frame leaves six frames after the multi-frame boundary.
// R3: First data frame leaves six frames after the multi-frame boundary.
// R4: Receiver settles sync request three frames before the boundary.
// R5: Sync request is sampled at the boundary; no hold needed after it.
// R6: Sync request held four frames forces a full restart.
// R7: Alignment sequence lasts exactly four multi-frames before data.
// R8: Lane bit rate stays between 1 and 7.4 Gb/s.
// R9: Receiver holds SYSREF high and low at least two frames each.
// R10: One frame per sample clock, one sample per converter.
// R11: Send K28.5 while requested, then alignment, then data.
`timescale 1ns/1ps
module jlit_link_init (
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire logic              SYSREF,
    input  wire logic              LINK_RESYNC_REQUEST_N,
    input  wire jlit_pkg::jlit_samples_t SAMPLES,
    output jlit_pkg::jlit_lanes_t  LANE_OUT,
    output jlit_pkg::jlit_state_t  LINK_STATE,
    output logic                   LMFC_BOUNDARY
);
    import jlit_pkg::*;

    // Lane rate is set by the serialiser; kept here for reference only, nothing checks it
    localparam int unsigned LANE_MBPS_NOM = LANE_MBPS_MAX; // R8

    logic        sysref_sync;
    logic        req_n_sync;
    logic        sysref_prev;
    logic [4:0]  lmfc_cnt;
    logic [4:0]  next_lmfc_cnt;
    logic        req_n_at_boundary;
    logic        next_req_n_at_boundary;
    jlit_state_t state;
    jlit_state_t next_state;
    logic [1:0]  ila_mf;
    logic [1:0]  next_ila_mf;
    logic [2:0]  hold_cnt;
    logic [2:0]  next_hold_cnt;
    jlit_lanes_t next_lanes;
    logic        next_boundary;
    logic        launch_pre;
    logic        resync_hit;

    // ==========================================================
    // Pin synchronisers
    jlit_sync2 u_sync_sysref (
        .clk       (REF_CLK),
        .rst       (RST),
        .rst_value (1'b0),
        .d         (SYSREF),
        .q         (sysref_sync)
    );

    // R4 setup of three frames covers the two synchroniser stages
    jlit_sync2 u_sync_req (
        .clk       (REF_CLK),
        .rst       (RST),
        .rst_value (1'b0),
        .d         (LINK_RESYNC_REQUEST_N),
        .q         (req_n_sync)
    );

    // ==========================================================
    // Frame builder
    function automatic jlit_lanes_t build_frame(input jlit_state_t st,
                                                input logic [4:0] pos,
                                                input jlit_samples_t smp);
        jlit_lanes_t f;
        f = '0;
        unique case (st)
            LS_WAIT: begin
                f = '0;
            end
            LS_CGS: begin
                f.a = '{ctrl: CTRL_BOTH, data: {CHAR_K, CHAR_K}}; // R11
                f.b = '{ctrl: CTRL_BOTH, data: {CHAR_K, CHAR_K}};
            end
            LS_ILA: begin
                // Filler is a ramp of the frame position; framing chars mark the ends
                f.a.data = {3'h0, pos, 3'h0, pos};
                f.a.ctrl = CTRL_NONE;
                if (pos == MF_FIRST) begin
                    f.a.data[15:8] = CHAR_R;
                    f.a.ctrl       = CTRL_HIGH;
                end else if (pos == MF_LAST) begin
                    f.a.data[7:0] = CHAR_A;
                    f.a.ctrl      = CTRL_LOW;
                end
                f.b = f.a;
            end
            LS_DATA: begin
                f.a = '{ctrl: CTRL_NONE, data: smp.a}; // R10
                f.b = '{ctrl: CTRL_NONE, data: smp.b};
            end
        endcase
        return f;
    endfunction : build_frame

    // ==========================================================
    // Local multi-frame counter, aligned by SYSREF rising edge
    always_comb begin
        next_lmfc_cnt          = lmfc_cnt + 5'h01;
        next_req_n_at_boundary = req_n_at_boundary;
        if (sysref_sync && !sysref_prev) begin
            next_lmfc_cnt = MF_FIRST;
        end
        if (lmfc_cnt == MF_FIRST) begin
            next_req_n_at_boundary = req_n_sync; // R5
        end
        next_boundary = (next_lmfc_cnt == MF_FIRST);
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            lmfc_cnt          <= MF_FIRST;
            sysref_prev       <= 1'b0;
            req_n_at_boundary <= 1'b0;
            LMFC_BOUNDARY     <= 1'b0;
        end else begin
            lmfc_cnt          <= next_lmfc_cnt;
            sysref_prev       <= sysref_sync;
            req_n_at_boundary <= next_req_n_at_boundary;
            LMFC_BOUNDARY     <= next_boundary;
        end
    end

    // ==========================================================
    // Link state machine; changes other than the resync restart to LS_WAIT land at the launch position
    assign launch_pre = (lmfc_cnt == LAUNCH_PRE);
    assign resync_hit = !req_n_sync && (hold_cnt == RESYNC_HOLD - 3'h1);

    always_comb begin
        next_state    = state;
        next_ila_mf   = ila_mf;
        next_hold_cnt = req_n_sync ? 3'h0 : hold_cnt;
        if (!req_n_sync && hold_cnt != RESYNC_HOLD) begin
            next_hold_cnt = hold_cnt + 3'h1;
        end
        unique case (state)
            LS_WAIT: begin
                if (launch_pre) begin
                    next_state = LS_CGS; // R1
                end
            end
            LS_CGS: begin
                if (launch_pre && req_n_at_boundary) begin
                    next_state  = LS_ILA; // R2
                    next_ila_mf = 2'h0;
                end
            end
            LS_ILA: begin
                if (resync_hit) begin
                    next_state = LS_WAIT; // R6
                end else if (launch_pre) begin
                    next_ila_mf = ila_mf + 2'h1;
                    if (ila_mf == ILA_LAST_MF) begin
                        next_state = LS_DATA; // R3 R7
                    end
                end
            end
            LS_DATA: begin
                if (resync_hit) begin
                    next_state = LS_WAIT; // R6
                end
            end
        endcase
        next_lanes = build_frame(next_state, 5'(lmfc_cnt - LAUNCH_PRE), SAMPLES);
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state    <= LS_WAIT;
            ila_mf   <= 2'h0;
            hold_cnt <= 3'h0;
            LANE_OUT <= '0;
        end else begin
            state    <= next_state;
            ila_mf   <= next_ila_mf;
            hold_cnt <= next_hold_cnt;
            LANE_OUT <= next_lanes;
        end
    end

    assign LINK_STATE = state;

    // ==========================================================
    // Checks
    logic [7:0] ila_cycles;

    always_ff @(posedge REF_CLK) begin
        if (RST || state != LS_ILA) begin
            ila_cycles <= 8'h00;
        end else begin
            ila_cycles <= ila_cycles + 8'h01;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_enter_cgs;
        state == LS_CGS && $past(state) == LS_WAIT;
    endsequence
    sequence s_enter_ila;
        state == LS_ILA && $past(state) == LS_CGS;
    endsequence
    sequence s_enter_data;
        state == LS_DATA && $past(state) == LS_ILA;
    endsequence

    a_cgs_launch_pos: assert property (s_enter_cgs |-> lmfc_cnt == LAUNCH_POS) // R1
        else $error("K28.5 phase began off the launch position");
    a_ila_launch_pos: assert property (s_enter_ila |-> lmfc_cnt == LAUNCH_POS && LANE_OUT.a.data[15:8] == CHAR_R) // R2
        else $error("Alignment phase began off the launch position");
    a_data_launch_pos: assert property (s_enter_data |-> lmfc_cnt == LAUNCH_POS) // R3
        else $error("Data phase began off the launch position");
    a_req_at_boundary: assert property (s_enter_ila |-> req_n_at_boundary) // R4
        else $error("Alignment started without a released request at the boundary");
    a_req_sample_time: assert property ($changed(req_n_at_boundary) |-> $past(lmfc_cnt) == MF_FIRST) // R5
        else $error("Request sampled away from the boundary");
    a_resync_restart: assert property ((state inside {LS_ILA, LS_DATA}) && resync_hit // R6
                                       |=> state == LS_WAIT ##[1:32] state == LS_CGS)
        else $error("Held request did not restart the link");
    a_ila_length_exact: assert property (s_enter_data // R7
                                         |-> $past(ila_cycles) == 8'(ILA_MULTIFRAMES * FRAMES_PER_MF - 1))
        else $error("Alignment sequence not four multi-frames long");
    a_data_per_frame: assert property (state == LS_DATA && $past(state) == LS_DATA // R10
                                       |-> LANE_OUT.a.data == $past(SAMPLES.a)
                                       && LANE_OUT.b.data == $past(SAMPLES.b))
        else $error("Sample not carried in the next frame");
    a_cgs_k_chars: assert property (state == LS_CGS |-> LANE_OUT.a.ctrl == CTRL_BOTH // R11
                                    && LANE_OUT.a.data == {CHAR_K, CHAR_K})
        else $error("Sync phase frame is not K28.5");

endmodule : jlit_link_init

// [bench/jlit_rx_model.sv]
/*
 * Receiver-side model of the sync request line.
 * Assumes the boundary pulse of the transmitter it faces, on the same clock.
 */
`timescale 1ns/1ps
module jlit_rx_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic link_up,
    input  wire logic boundary,
    output logic      link_resync_request_n
);
    int   hold = 0;
    logic released = 1'b0;

    // ====================
    // Request line
    initial link_resync_request_n = 1'b0;
    always @(posedge clk) begin
        if (rst || !link_up) begin
            link_resync_request_n <= 1'b0;
            released              <= 1'b0;
        end else if (hold > 0) begin
            link_resync_request_n <= 1'b0;
            hold                  <= hold - 1;
        end else if (released || boundary) begin
            // Releasing just after a boundary leaves 31 frames of setup before the next one
            link_resync_request_n <= 1'b1;
            released              <= 1'b1;
        end
    end

    task automatic resync(input int n);
        hold <= n;
    endtask : resync
endmodule : jlit_rx_model

// [bench/jlit_link_init_tb.sv]
/*
 * Self-checking bench of the link start-up sequencer.
 * Assumes the receiver model drives the sync request.
 */
`timescale 1ns/1ps
module jlit_link_init_tb;
    import jlit_pkg::*;
    logic          REF_CLK = 1'b0;
    logic          RST = 1'b1;
    logic          SYSREF = 1'b0;
    logic          link_up = 1'b0;
    logic          link_resync_request_n;
    jlit_samples_t SAMPLES = '{a: 16'h1234, b: 16'h0000};
    jlit_lanes_t   LANE_OUT;
    jlit_state_t   LINK_STATE;
    logic          LMFC_BOUNDARY;
    int            errors = 0;
    int            checks_done = 0;
    int            n;
    int            since;
    jlit_samples_t smp;
    localparam logic [35:0] K_FRAME = {CTRL_BOTH, CHAR_K, CHAR_K, CTRL_BOTH, CHAR_K, CHAR_K};
    // Falling edges from the SYSREF drive edge to the boundary: two sync stages, then the counter load
    localparam int          SYSREF_TO_BOUNDARY = 4;

    always #25 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) SAMPLES <= '{a: SAMPLES.a + 16'h0001, b: ~SAMPLES.a};

    jlit_link_init dut (.REF_CLK(REF_CLK), .RST(RST), .SYSREF(SYSREF),
        .LINK_RESYNC_REQUEST_N(link_resync_request_n), .SAMPLES(SAMPLES),
        .LANE_OUT(LANE_OUT), .LINK_STATE(LINK_STATE), .LMFC_BOUNDARY(LMFC_BOUNDARY));
    jlit_rx_model rx (.clk(REF_CLK), .rst(RST), .link_up(link_up), .boundary(LMFC_BOUNDARY),
        .link_resync_request_n(link_resync_request_n));

    // ====================
    // Reporting
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check_bits(input string what, input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_bits

    task automatic check_count(input string what, input int exp, input int got);
        checks_done++;
        if (got != exp) begin
            errors++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_count

    task automatic timeout(input string what);
        errors++;
        $display("MISMATCH timeout waiting for %s", what);
        print_verdict();
    endtask : timeout

    // ====================
    // Waits, bounded
    task automatic wait_boundary(output int cyc);
        cyc = 0;
        do begin
            @(negedge REF_CLK);
            cyc++;
        end while (LMFC_BOUNDARY !== 1'b1 && cyc < 64);
        if (cyc >= 64) timeout("boundary");
    endtask : wait_boundary

    // Returns frames since the last seen boundary and cycles waited
    task automatic wait_state(input jlit_state_t st, output int sb, output int cyc);
        sb = -100;
        cyc = 0;
        do begin
            @(negedge REF_CLK);
            cyc++;
            sb = (LMFC_BOUNDARY === 1'b1) ? 0 : sb + 1;
        end while (LINK_STATE !== st && cyc < 300);
        if (cyc >= 300) timeout(st.name());
    endtask : wait_state

    // ====================
    // Scenarios
    task automatic scn_sysref();
        @(posedge REF_CLK);
        SYSREF <= 1'b1;
        // Without realignment the first boundary would only come with the counter wrap
        wait_boundary(n);
        check_count("sysref to boundary", SYSREF_TO_BOUNDARY, n);
        @(posedge REF_CLK);
        SYSREF <= 1'b0;
        wait_boundary(n);
        check_count("multi-frame length", FRAMES_PER_MF, n);
    endtask : scn_sysref

    task automatic scn_link_up();
        check_bits("cgs state", 36'(LS_CGS), 36'(LINK_STATE));
        check_bits("cgs lanes", K_FRAME, LANE_OUT);
        @(posedge REF_CLK);
        link_up <= 1'b1;
        wait_state(LS_ILA, since, n);
        check_count("ila launch offset", LAUNCH_FRAMES, since);
        check_bits("ila first octet", 36'({CTRL_HIGH, CHAR_R}), 36'({LANE_OUT.a.ctrl, LANE_OUT.a.data[15:8]}));
        wait_state(LS_DATA, since, n);
        check_count("ila length", ILA_MULTIFRAMES * FRAMES_PER_MF, n);
        check_count("data launch offset", LAUNCH_FRAMES, since);
        repeat (4) begin
            smp = SAMPLES;
            @(negedge REF_CLK);
            check_bits("data lanes", {CTRL_NONE, smp.a, CTRL_NONE, smp.b}, LANE_OUT);
        end
    endtask : scn_link_up

    task automatic scn_resync();
        wait_boundary(n);
        @(posedge REF_CLK);
        rx.resync(RESYNC_FRAMES - 1);
        repeat (12) @(negedge REF_CLK);
        check_bits("short request ignored", 36'(LS_DATA), 36'(LINK_STATE));
        wait_boundary(n);
        @(posedge REF_CLK);
        rx.resync(RESYNC_FRAMES);
        wait_state(LS_WAIT, since, n);
        wait_state(LS_CGS, since, n);
        check_count("cgs launch offset", LAUNCH_FRAMES, since);
        check_bits("cgs lanes again", K_FRAME, LANE_OUT);
    endtask : scn_resync

    initial begin
        repeat (5) @(posedge REF_CLK);
        RST <= 1'b0;
        @(negedge REF_CLK);
        check_bits("state after reset", 36'(LS_WAIT), 36'(LINK_STATE));
        scn_sysref();
        scn_link_up();
        scn_resync();
        print_verdict();
    end
endmodule : jlit_link_init_tb
